// ==== include/reset_power_defs.vh ====
// constants for the reset source and power mode block
`ifndef RESET_POWER_DEFS_VH
`define RESET_POWER_DEFS_VH
`define ADDR_BOOT_CTRL 8'he7
`define ADDR_CAUSE 8'h97
`define ADDR_PWR_CTRL 8'h87
`define ADDR_PWR_CFG 8'ha7
`define ADDR_CLK_CFG 8'hc7
`define ADDR_IRQ_EN 8'h8e
`define ADDR_WDT_CFG 8'he1
`define BIT_SOFT_BOOT 6
`define BIT_SOFT_TRIG 5
`define BIT_SOFT_FLAG 7
`define BIT_EXT_FLAG 6
`define BIT_RTC_FLAG 4
`define BIT_SEL_FLAG 2
`define BIT_FIX_FLAG 1
`define BIT_WDT_FLAG 0
`define BIT_PD 1
`define BIT_IDL 0
`define BIT_WAKE_EN 7
`define BIT_SEL_RST_EN 3
`define BIT_SEL_DET_EN 2
`define BIT_FIX_RST_EN 1
`define BIT_SYS_IRQ_EN 7
`define BIT_RTC_IRQ_EN 4
`define BIT_WDT_RST_EN 7
`define BIT_WDT_NONSTOP 6
`define BIT_WDT_IRQ_EN 0
`define BIT_FIX_IRQ_EN 1
`define BIT_SEL_IRQ_EN 2
`define BIT_RSV_HI 5
`define BIT_RSV_LO 3
`define FLD_DIV_HI 2
`define FLD_DIV_LO 0
`define FLD_OSC_HI 5
`define FLD_OSC_LO 4
`define FLD_LVL_HI 7
`define FLD_LVL_LO 6
`define CAUSE_RESET 8'h00
`define PCFG_RESET 8'h04
`define RST_PULSE_CYC 4'h8
`define ZERO8 8'h00
`endif

// ==== design/reset_power_ctrl.v ====
// reset cause flags, soft reset, brown-out supervision and power modes
`timescale 1ns/1ns
`include "reset_power_defs.vh"
module reset_power_ctrl #(
  parameter RST_CYC = 8
) (
  // clock and power-on reset
  input wire clk_sys,
  input wire arst_n,
  // special-function register port
  input wire sfrWe,
  input wire sfrRe,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  output reg [7:0] sfrRdata_q,
  // asynchronous sources, synchronised here
  input wire extResetPin,
  input wire fixedBrownoutDetector,
  input wire selectableBrownoutDetector,
  // same-clock events
  input wire watchdogOverflow,
  input wire rtcOverflow,
  input wire illegalAddress,
  input wire wakeIrq,
  // system outputs
  output reg sysReset_q,
  output reg bootFromIsp_q,
  output reg systemFlagIrq_q,
  output reg powerDown_q,
  output reg idle_q,
  output reg [1:0] selectableLevel_q,
  output reg selectableDetectorEnable_q,
  output reg [2:0] sysclkDividerSelect_q,
  output reg [1:0] oscillatorSelect_q,
  output reg watchdogNonstop_q
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam SYNC_W = 3;
  wire [SYNC_W-1:0] asyncIn;
  wire [SYNC_W-1:0] syncOut;
  reg extPrev_q;
  genvar g;
  assign asyncIn = {extResetPin, fixedBrownoutDetector, selectableBrownoutDetector};
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : gSync
      reg stageA_q;
      reg stageB_q;
      // only the second stage is read, the first may still be settling
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          stageA_q <= 1'b0;
          stageB_q <= 1'b0;
        end else begin
          stageA_q <= asyncIn[g];
          stageB_q <= stageA_q;
        end
      end
      assign syncOut[g] = stageB_q;
    end
  endgenerate

  // pin idles low, so a zero reset value gives no false edge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= syncOut[2];
    end
  end
  wire extLvl = syncOut[2];
  wire extEvt = extLvl & ~extPrev_q;
  wire fixEvt = syncOut[1];
  // detector output ignored while disabled so it can be powered off
  wire selEvt = syncOut[0] & selectableDetectorEnable_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] cause_q;
  reg softBoot_q;
  reg softTrig_q;
  reg [7:0] pwrCfg_q;
  reg [7:0] irqEn_q;
  reg [7:0] wdtCfg_q;
  reg [3:0] rstCnt_q;

  function wr;
    input [7:0] a;
    begin
      wr = sfrWe && (sfrAddr == a);
    end
  endfunction

  wire fixRstEn = pwrCfg_q[`BIT_FIX_RST_EN];
  wire selRstEn = pwrCfg_q[`BIT_SEL_RST_EN];
  wire wakeEn = pwrCfg_q[`BIT_WAKE_EN];
  wire wdtRstEn = wdtCfg_q[`BIT_WDT_RST_EN];
  // power-down gates fixed detector and the selectable one without wake enable
  wire fixRst = fixEvt & fixRstEn & ~powerDown_q;
  wire selRst = selEvt & selRstEn & (~powerDown_q | wakeEn);
  wire wdtRst = watchdogOverflow & wdtRstEn;
  wire anyRst = extEvt | softTrig_q | fixRst | selRst | wdtRst | illegalAddress;
  wire cw = wr(`ADDR_CAUSE);

  // ------------------------------------------------------------
  // cause flags: set beats write-one-to-clear, kept across system resets
  // ------------------------------------------------------------
  // one set term per flag; the two unused bits have no source
  wire [7:0] setV;
  assign setV[`BIT_SOFT_FLAG] = softTrig_q;
  assign setV[`BIT_EXT_FLAG] = extEvt;
  assign setV[`BIT_RSV_HI] = 1'b0;
  assign setV[`BIT_RTC_FLAG] = rtcOverflow;
  assign setV[`BIT_RSV_LO] = 1'b0;
  assign setV[`BIT_SEL_FLAG] = selEvt;
  assign setV[`BIT_FIX_FLAG] = fixEvt & ~powerDown_q;
  assign setV[`BIT_WDT_FLAG] = watchdogOverflow;
  wire [7:0] clrV = cw ? sfrWdata : `ZERO8;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cause_q <= `CAUSE_RESET;
    end else begin
      cause_q <= (cause_q & ~clrV) | setV;
    end
  end

  // ------------------------------------------------------------
  // configuration registers; they ride through the system reset pulse
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      softBoot_q <= 1'b0;
      softTrig_q <= 1'b0;
    end else begin
      // trigger lasts one cycle, then clears itself
      softTrig_q <= wr(`ADDR_BOOT_CTRL) & sfrWdata[`BIT_SOFT_TRIG] & ~sysReset_q;
      if (wr(`ADDR_BOOT_CTRL)) begin
        softBoot_q <= sfrWdata[`BIT_SOFT_BOOT];
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwrCfg_q <= `PCFG_RESET;
    end else if (wr(`ADDR_PWR_CFG)) begin
      pwrCfg_q <= sfrWdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_q <= `ZERO8;
    end else if (wr(`ADDR_IRQ_EN)) begin
      irqEn_q <= sfrWdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wdtCfg_q <= `ZERO8;
    end else if (wr(`ADDR_WDT_CFG)) begin
      wdtCfg_q <= sfrWdata;
    end
  end

  // selects steer the clock generator and the level steers the selectable detector, both outside this block
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sysclkDividerSelect_q <= 3'h0;
      oscillatorSelect_q <= 2'h0;
      selectableLevel_q <= 2'h0;
    end else if (wr(`ADDR_CLK_CFG)) begin
      sysclkDividerSelect_q <= sfrWdata[`FLD_DIV_HI:`FLD_DIV_LO];
      oscillatorSelect_q <= sfrWdata[`FLD_OSC_HI:`FLD_OSC_LO];
      selectableLevel_q <= sfrWdata[`FLD_LVL_HI:`FLD_LVL_LO];
    end
  end

  // ------------------------------------------------------------
  // merged system reset pulse
  // ------------------------------------------------------------
  // a new source restarts the count, so back-to-back causes stretch the pulse
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstCnt_q <= `RST_PULSE_CYC;
    end else if (anyRst) begin
      rstCnt_q <= RST_CYC[3:0];
    end else if (rstCnt_q != 4'h0) begin
      rstCnt_q <= rstCnt_q - 4'h1;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sysReset_q <= 1'b1;
      bootFromIsp_q <= 1'b0;
    end else begin
      if (anyRst) begin
        bootFromIsp_q <= softTrig_q ? softBoot_q : 1'b0;
      end
      // external pin held high keeps the chip in reset
      sysReset_q <= anyRst | extLvl | (rstCnt_q != 4'h0);
    end
  end

  // ------------------------------------------------------------
  // interrupt, power modes and wake
  // ------------------------------------------------------------
  wire sysIrqEn = irqEn_q[`BIT_SYS_IRQ_EN];
  wire fixIrq = cause_q[`BIT_FIX_FLAG] & irqEn_q[`BIT_FIX_IRQ_EN];
  wire selIrq = cause_q[`BIT_SEL_FLAG] & irqEn_q[`BIT_SEL_IRQ_EN];
  wire rtcIrq = cause_q[`BIT_RTC_FLAG] & irqEn_q[`BIT_RTC_IRQ_EN];
  wire wdtIrq = cause_q[`BIT_WDT_FLAG] & wdtCfg_q[`BIT_WDT_IRQ_EN];
  wire nonstop = wdtCfg_q[`BIT_WDT_NONSTOP];
  // only the monitor, rtc and non-stop watchdog paths live in power-down
  wire pdIrq = sysIrqEn & ((selIrq & wakeEn) | rtcIrq | (wdtIrq & nonstop));
  wire runIrq = sysIrqEn & (fixIrq | selIrq | rtcIrq | wdtIrq);
  wire pdWake = pdIrq | wakeIrq | sysReset_q;
  wire idleWake = runIrq | wakeIrq | sysReset_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      systemFlagIrq_q <= 1'b0;
      watchdogNonstop_q <= 1'b0;
    end else begin
      watchdogNonstop_q <= nonstop & wdtCfg_q[`BIT_WDT_IRQ_EN] | nonstop & wdtRstEn;
      systemFlagIrq_q <= powerDown_q ? pdIrq : runIrq;
    end
  end

  // a wake event beats a write in the same cycle, so no wake is lost
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      powerDown_q <= 1'b0;
    end else if (powerDown_q & pdWake) begin
      powerDown_q <= 1'b0;
    end else if (wr(`ADDR_PWR_CTRL)) begin
      powerDown_q <= sfrWdata[`BIT_PD];
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 1'b0;
    end else if (idle_q & idleWake) begin
      idle_q <= 1'b0;
    end else if (wr(`ADDR_PWR_CTRL)) begin
      idle_q <= sfrWdata[`BIT_IDL];
    end
  end

  // ------------------------------------------------------------
  // readback
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdata_q <= `ZERO8;
    end else if (sfrRe) begin
      case (sfrAddr)
        `ADDR_CAUSE: sfrRdata_q <= cause_q;
        `ADDR_BOOT_CTRL: sfrRdata_q <= {1'b0, softBoot_q, softTrig_q, 5'h00};
        `ADDR_PWR_CTRL: sfrRdata_q <= {6'h00, powerDown_q, idle_q};
        `ADDR_PWR_CFG: sfrRdata_q <= pwrCfg_q;
        `ADDR_IRQ_EN: sfrRdata_q <= irqEn_q;
        `ADDR_WDT_CFG: sfrRdata_q <= wdtCfg_q;
        `ADDR_CLK_CFG: sfrRdata_q <= {selectableLevel_q, oscillatorSelect_q,
                                      1'b0, sysclkDividerSelect_q};
        default: sfrRdata_q <= `ZERO8;
      endcase
    end
  end

  // enable lags its register bit by one cycle
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      selectableDetectorEnable_q <= 1'b1;
    end else begin
      selectableDetectorEnable_q <= pwrCfg_q[`BIT_SEL_DET_EN];
    end
  end
endmodule

// ==== tb/reset_power_props.sv ====
// concurrent checks on the reset and power block ports
`timescale 1ns/1ns
`include "reset_power_defs.vh"
module reset_power_props #(
  parameter RST_CYC = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // register port
  input wire sfrWe,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  // events
  input wire extResetPin,
  input wire illegalAddress,
  input wire wakeIrq,
  // watched outputs
  input wire sysReset_q,
  input wire bootFromIsp_q,
  input wire powerDown_q,
  input wire idle_q,
  input wire [1:0] oscillatorSelect_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // trigger only counts outside a running reset, where it is ignored
  wire softWr = sfrWe && sfrAddr == `ADDR_BOOT_CTRL && sfrWdata[5] && !sysReset_q;
  wire clkWr = sfrWe && sfrAddr == `ADDR_CLK_CFG && !sysReset_q;
  wire [1:0] oscWr = sfrWdata[5:4];
  a_soft_trig_reset: assert property (softWr |-> ##[1:3] sysReset_q)
    else $error("soft trigger gave no reset");
  a_boot_isp_sel: assert property (softWr && sfrWdata[6] |-> ##[2:4] bootFromIsp_q)
    else $error("boot region not programming");
  a_boot_app_sel: assert property (softWr && !sfrWdata[6] |-> ##[2:4] !bootFromIsp_q)
    else $error("boot region not application");
  a_reset_pulse_len: assert property ($fell(sysReset_q) |-> $past(sysReset_q, RST_CYC))
    else $error("system reset too short");
  a_illegal_addr_rst: assert property (illegalAddress |-> ##[1:3] sysReset_q)
    else $error("illegal address gave no reset");
  a_ext_pin_rst: assert property ($rose(extResetPin) |-> ##[2:5] sysReset_q)
    else $error("external pin gave no reset");
  a_pd_wake_exit: assert property (powerDown_q && wakeIrq |-> ##[1:2] !powerDown_q)
    else $error("power-down not left on wake");
  a_idle_wake_exit: assert property (idle_q && wakeIrq |-> ##[1:2] !idle_q)
    else $error("idle not left on wake");
  a_osc_sel_write: assert property (clkWr |=> oscillatorSelect_q == $past(oscWr))
    else $error("oscillator select not written");
endmodule
bind reset_power_ctrl reset_power_props #(.RST_CYC(RST_CYC)) props_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .sfrWe(sfrWe), .sfrAddr(sfrAddr),
  .sfrWdata(sfrWdata), .extResetPin(extResetPin), .illegalAddress(illegalAddress),
  .wakeIrq(wakeIrq), .sysReset_q(sysReset_q), .bootFromIsp_q(bootFromIsp_q),
  .powerDown_q(powerDown_q), .idle_q(idle_q), .oscillatorSelect_q(oscillatorSelect_q)
);

// ==== tb/testbench.sv ====
// self-checking bench for the reset and power block
`timescale 1ns/1ns
`include "reset_power_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module testbench;
  reg clk_sys = 0, arst_n = 0, sfrWe = 0, sfrRe = 0, wakeIrq = 0;
  reg extResetPin = 0, fixBo = 0, selBo = 0, wdo = 0, rtco = 0, ill = 0;
  reg [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, rd;
  wire [7:0] sfrRdata_q;
  wire sysReset_q, bootFromIsp_q, systemFlagIrq_q, powerDown_q, idle_q, selEn, nonstop;
  wire [1:0] level, osc;
  wire [2:0] div;
  integer err_count = 0, n_checks = 0, i, k;
  initial forever #50 clk_sys = ~clk_sys;
  // short pulse keeps the run brief
  reset_power_ctrl #(.RST_CYC(2)) reset_power_ctrl_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata_q(sfrRdata_q), .extResetPin(extResetPin),
    .fixedBrownoutDetector(fixBo), .selectableBrownoutDetector(selBo),
    .watchdogOverflow(wdo), .rtcOverflow(rtco), .illegalAddress(ill), .wakeIrq(wakeIrq),
    .sysReset_q(sysReset_q), .bootFromIsp_q(bootFromIsp_q),
    .systemFlagIrq_q(systemFlagIrq_q), .powerDown_q(powerDown_q), .idle_q(idle_q),
    .selectableLevel_q(level), .selectableDetectorEnable_q(selEn),
    .sysclkDividerSelect_q(div), .oscillatorSelect_q(osc), .watchdogNonstop_q(nonstop));
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    sfrWe = 1;
    sfrAddr = a;
    sfrWdata = d;
    tick(1);
    sfrWe = 0;
    tick(1);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    sfrRe = 1;
    sfrAddr = a;
    tick(1);
    sfrRe = 0;
    rd = sfrRdata_q;
    `CHK(rd, e)
    tick(1);
  endtask
  // flag seen, then cleared by writing ones (reserved bit 3 written zero, reserved bit 5 written one)
  task flag(input [7:0] e);
    rdc(`ADDR_CAUSE, e);
    wr(`ADDR_CAUSE, 8'hf7);
    rdc(`ADDR_CAUSE, `ZERO8);
  endtask
  task cyc;
    for (i = 0; i < 20 && sysReset_q !== 1'b1; i++) tick(1);
    `CHK(sysReset_q, 1'b1)
    for (i = 0; i < 40 && sysReset_q !== 1'b0; i++) tick(1);
    `CHK(sysReset_q, 1'b0)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    final_report;
  end
  initial begin
    tick(16);
    arst_n = 1;
    cyc;
    rdc(`ADDR_CAUSE, `CAUSE_RESET);
    rdc(8'h00, `ZERO8);
    rdc(`ADDR_PWR_CFG, `PCFG_RESET);
    for (k = 0; k < 2; k++) begin
      wr(`ADDR_PWR_CTRL, 8'h01 << k);
      tick(1);
      `CHK({powerDown_q, idle_q}, 2'b01 << k)
      wakeIrq = 1;
      tick(2);
      `CHK({powerDown_q, idle_q}, 2'b00)
      wakeIrq = 0;
    end
    wr(`ADDR_CLK_CFG, 8'hb5);
    tick(1);
    `CHK({level, osc, div}, 7'h5d)
    $display("test modes done");
    wr(`ADDR_BOOT_CTRL, 8'h60);
    cyc;
    `CHK(bootFromIsp_q, 1'b1)
    rdc(`ADDR_BOOT_CTRL, 8'h40);
    wr(`ADDR_CAUSE, 8'h00);
    flag(8'h80);
    wr(`ADDR_BOOT_CTRL, 8'h20);
    cyc;
    `CHK(bootFromIsp_q, 1'b0)
    flag(8'h80);
    extResetPin = 1;
    tick(4);
    extResetPin = 0;
    cyc;
    flag(8'h40);
    $display("test soft and pin done");
    wr(`ADDR_PWR_CFG, 8'h06);
    fixBo = 1;
    tick(4);
    fixBo = 0;
    cyc;
    flag(8'h02);
    wr(`ADDR_PWR_CFG, 8'h08);
    `CHK(selEn, 1'b0)
    selBo = 1;
    tick(6);
    selBo = 0;
    tick(4);
    `CHK(sysReset_q, 1'b0)
    rdc(`ADDR_CAUSE, `ZERO8);
    wr(`ADDR_PWR_CFG, 8'h84);
    `CHK(selEn, 1'b1)
    wr(`ADDR_IRQ_EN, 8'h84);
    wr(`ADDR_PWR_CTRL, 8'h02);
    tick(1);
    `CHK(powerDown_q, 1'b1)
    selBo = 1;
    tick(4);
    selBo = 0;
    tick(2);
    `CHK({powerDown_q, systemFlagIrq_q, sysReset_q}, 3'b010)
    flag(8'h04);
    `CHK(systemFlagIrq_q, 1'b0)
    wr(`ADDR_IRQ_EN, 8'h00);
    wr(`ADDR_PWR_CFG, 8'h0c);
    selBo = 1;
    tick(4);
    selBo = 0;
    cyc;
    flag(8'h04);
    $display("test brown-out done");
    wr(`ADDR_WDT_CFG, 8'hc0);
    tick(1);
    `CHK(nonstop, 1'b1)
    wdo = 1;
    tick(1);
    wdo = 0;
    cyc;
    flag(8'h01);
    rtco = 1;
    tick(1);
    rtco = 0;
    tick(2);
    flag(8'h10);
    wr(`ADDR_IRQ_EN, 8'h90);
    wr(`ADDR_PWR_CTRL, 8'h02);
    rtco = 1;
    tick(1);
    rtco = 0;
    tick(2);
    `CHK({powerDown_q, systemFlagIrq_q}, 2'b01)
    flag(8'h10);
    wr(`ADDR_WDT_CFG, 8'h41);
    wr(`ADDR_IRQ_EN, 8'h80);
    wr(`ADDR_PWR_CTRL, 8'h02);
    wdo = 1;
    tick(1);
    wdo = 0;
    tick(2);
    `CHK({powerDown_q, systemFlagIrq_q, sysReset_q}, 3'b010)
    flag(8'h01);
    wr(`ADDR_PWR_CFG, 8'h8e);
    wr(`ADDR_PWR_CTRL, 8'h02);
    fixBo = 1;
    tick(4);
    fixBo = 0;
    tick(3);
    `CHK({powerDown_q, sysReset_q}, 2'b10)
    rdc(`ADDR_CAUSE, `ZERO8);
    selBo = 1;
    tick(4);
    selBo = 0;
    cyc;
    `CHK(powerDown_q, 1'b0)
    flag(8'h04);
    ill = 1;
    tick(1);
    ill = 0;
    cyc;
    rdc(`ADDR_CAUSE, `ZERO8);
    $display("test watchdog rtc illegal done");
    final_report;
  end
endmodule
